/* core/poc_delay.sv */
// Shift register with every stage visible
`default_nettype none
module poc_delay #(
  parameter int W = 1,
  parameter int N = 2
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [W-1:0] d_i,
  output logic [N-1:0][W-1:0] taps_o
);
  typedef struct packed {
    logic [N-1:0][W-1:0] stage;
  } poc_delay_s;

  poc_delay_s q;
  poc_delay_s next_q;

  always_comb begin
    next_q = q;
    next_q.stage[0] = d_i;
    for (int i = 1; i < N; i++) begin
      next_q.stage[i] = q.stage[i-1];
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign taps_o = q.stage;
endmodule : poc_delay
`default_nettype wire

/* core/poc_output.sv */
// Pixel data output stage with phase shift and data clock select
`default_nettype none
module poc_output
  import poc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic external_pixel_clock_input_i,
  input wire logic pixel_source_external_i,
  input wire logic [SAMPLE_W-1:0] red_sample_i,
  input wire logic [SAMPLE_W-1:0] green_sample_i,
  input wire logic [SAMPLE_W-1:0] blue_sample_i,
  input wire logic hsync_regen_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rd_data_o,
  output logic [SAMPLE_W-1:0] red_o,
  output logic [SAMPLE_W-1:0] green_o,
  output logic [SAMPLE_W-1:0] blue_o,
  output logic horizontal_sync_output_o,
  output logic output_data_clock_o
);
  localparam int PIPE_W = 3 * SAMPLE_W + 2;

  typedef struct packed {
    logic [7:0] sampling_phase;
    logic [7:0] output_clock_config;
    logic [7:0] rd_data;
    logic [1:0] pll_cnt;
    logic [1:0] pix_cnt;
    logic [1:0] osc_cnt;
    logic osc;
    logic [SAMPLE_W-1:0] red;
    logic [SAMPLE_W-1:0] green;
    logic [SAMPLE_W-1:0] blue;
    logic hsync;
    logic dclk;
  } poc_state_s;

  poc_state_s q;
  poc_state_s next_q;

  // ==========================================================
  // Pin synchronisers and pixel strobe
  logic [SYNC_DEPTH-1:0][1:0] sync_taps;
  logic [PHASE_TAPS-1:0][0:0] phase_taps;
  logic [PIPE_DEPTH-1:0][PIPE_W-1:0] pipe_taps;
  logic ext_sel;
  logic ext_edge;
  logic base_strobe;
  logic sample_stb;
  logic [PIPE_W-1:0] pipe_out;
  logic upd;
  logic [1:0] dclk_sel;

  poc_delay #(.W(2), .N(SYNC_DEPTH)) u_sync (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .d_i({pixel_source_external_i, external_pixel_clock_input_i}),
    .taps_o(sync_taps)
  );

  assign ext_sel = sync_taps[1][1];
  assign ext_edge = sync_taps[1][0] & ~sync_taps[2][0];
  // Pixel timing from PLL divider or external clock edge
  assign base_strobe = ext_sel ? ext_edge : (q.pll_cnt == PLL_LAST);

  poc_delay #(.W(1), .N(PHASE_TAPS)) u_phase (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .d_i(base_strobe),
    .taps_o(phase_taps)
  );

  // Phase delays only the sampling strobe; everything downstream follows it
  assign sample_stb = phase_taps[q.sampling_phase[PHASE_MSB:PHASE_LSB]][0];

  poc_delay #(.W(PIPE_W), .N(PIPE_DEPTH)) u_pipe (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .d_i({sample_stb, hsync_regen_i, red_sample_i, green_sample_i, blue_sample_i}),
    .taps_o(pipe_taps)
  );

  assign pipe_out = pipe_taps[PIPE_DEPTH-1];
  assign upd = pipe_out[PIPE_W-1];
  assign dclk_sel = q.output_clock_config[DCLK_SEL_MSB:DCLK_SEL_LSB];

  // ==========================================================
  // Next state
  always_comb begin
    next_q = q;
    next_q.pll_cnt = q.pll_cnt + 2'h1;
    // Internal oscillator runs free of any pixel strobe
    if (q.osc_cnt == 2'(OSC_HALF_CYC - 1)) begin
      next_q.osc_cnt = 2'h0;
      next_q.osc = ~q.osc;
    end else begin
      next_q.osc_cnt = q.osc_cnt + 2'h1;
    end
    if (reg_wr_i && reg_addr_i == SAMPLING_PHASE_OFS) begin
      next_q.sampling_phase = reg_wdata_i;
    end
    if (reg_wr_i && reg_addr_i == OUTPUT_CLOCK_CONFIG_OFS) begin
      next_q.output_clock_config = reg_wdata_i;
    end
    case (reg_addr_i)
      SAMPLING_PHASE_OFS: next_q.rd_data = q.sampling_phase;
      OUTPUT_CLOCK_CONFIG_OFS: next_q.rd_data = q.output_clock_config;
      default: next_q.rd_data = 8'h00;
    endcase
    // Data, sync and pixel clock phase all restart on the same update
    if (upd) begin
      next_q.pix_cnt = 2'h0;
      next_q.red = pipe_out[3*SAMPLE_W-1:2*SAMPLE_W];
      next_q.green = pipe_out[2*SAMPLE_W-1:SAMPLE_W];
      next_q.blue = pipe_out[SAMPLE_W-1:0];
      next_q.hsync = pipe_out[PIPE_W-2];
    end else begin
      next_q.pix_cnt = q.pix_cnt + 2'h1;
    end
    // With DCLK_PIXEL the rising data clock edge falls mid-way through each data word
    case (dclk_sel)
      DCLK_PIXEL: next_q.dclk = next_q.pix_cnt[1];
      DCLK_PIXEL_Q90: next_q.dclk = next_q.pix_cnt[1] ^ ~next_q.pix_cnt[0];
      DCLK_PIXEL_X2: next_q.dclk = next_q.pix_cnt[0];
      DCLK_INTERNAL: next_q.dclk = next_q.osc;
      default: next_q.dclk = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= '0;
      q.sampling_phase <= SAMPLING_PHASE_RST;
      q.output_clock_config <= OUTPUT_CLOCK_CONFIG_RST;
    end else begin
      q <= next_q;
    end
  end

  assign reg_rd_data_o = q.rd_data;
  assign red_o = q.red;
  assign green_o = q.green;
  assign blue_o = q.blue;
  assign horizontal_sync_output_o = q.hsync;
  assign output_data_clock_o = q.dclk;

  // ==========================================================
  // Checks
  AST_RED_LATENCY: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    sample_stb |-> ##3 red_o == $past(red_sample_i, 3))
    else $error("red output latency wrong");
  AST_BLUE_MSB: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    sample_stb |-> ##3 blue_o[7] == $past(blue_sample_i[7], 3))
    else $error("blue msb misplaced");
  AST_HSYNC_WITH_DATA: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    sample_stb |-> ##3 (horizontal_sync_output_o == $past(hsync_regen_i, 3))
      && (green_o == $past(green_sample_i, 3)))
    else $error("sync output not aligned with data");
  // Phase 2 picks the third tap: strobe shows three edges after the base strobe
  AST_PHASE_SHIFT: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    base_strobe && q.sampling_phase[1:0] == 2'h2 && !reg_wr_i ##1 !reg_wr_i [*2]
      |=> sample_stb)
    else $error("sampling phase shift wrong");
  AST_PIX_CLK: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    upd && dclk_sel == DCLK_PIXEL ##1 (!upd && dclk_sel == DCLK_PIXEL) [*2]
      |=> output_data_clock_o && $past(!output_data_clock_o, 2))
    else $error("pixel data clock wrong");
  AST_Q90_CLK: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    upd && dclk_sel == DCLK_PIXEL_Q90 ##1 (!upd && dclk_sel == DCLK_PIXEL_Q90)
      |=> !output_data_clock_o && $past(output_data_clock_o))
    else $error("shifted data clock wrong");
  AST_X2_CLK: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    upd && dclk_sel == DCLK_PIXEL_X2 ##1 (!upd && dclk_sel == DCLK_PIXEL_X2)
      |=> output_data_clock_o && $past(!output_data_clock_o))
    else $error("double rate data clock wrong");
  // Free oscillator at its shortest half period: toggles every cycle
  AST_INT_CLK: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    dclk_sel == DCLK_INTERNAL ##1 dclk_sel == DCLK_INTERNAL
      |=> output_data_clock_o != $past(output_data_clock_o))
    else $error("internal data clock wrong");
  AST_EXT_SOURCE: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    ext_sel && ext_edge |=> phase_taps[0][0])
    else $error("external clock edge lost");
  AST_CFG_WRITE: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    reg_wr_i && reg_addr_i == OUTPUT_CLOCK_CONFIG_OFS ##1 reg_addr_i == OUTPUT_CLOCK_CONFIG_OFS
      |=> reg_rd_data_o == $past(reg_wdata_i, 2))
    else $error("config register readback wrong");

  COV_PHASE_MOVE: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    reg_wr_i && reg_addr_i == SAMPLING_PHASE_OFS ##[1:20] upd);
  COV_EXT_CLOCK: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    ext_sel && ext_edge);
  COV_X2_SEL: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    dclk_sel == DCLK_PIXEL_X2 && upd);
  COV_INT_SEL: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    dclk_sel == DCLK_INTERNAL ##1 $rose(output_data_clock_o));
endmodule : poc_output
`default_nettype wire

/* core/poc_pkg.sv */
// Constants shared by the pixel output and clock select block
`default_nettype none
package poc_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] SAMPLING_PHASE_OFS = 8'h04;
  localparam logic [7:0] OUTPUT_CLOCK_CONFIG_OFS = 8'h20;
  localparam logic [7:0] SAMPLING_PHASE_RST = 8'h00;
  localparam logic [7:0] OUTPUT_CLOCK_CONFIG_RST = 8'h00;
  // Data clock select field of output_clock_config
  localparam int DCLK_SEL_MSB = 7;
  localparam int DCLK_SEL_LSB = 6;
  // Sampling phase steps used from sampling_phase
  localparam int PHASE_MSB = 1;
  localparam int PHASE_LSB = 0;
  // ==========================================================
  // Data clock sources
  localparam logic [1:0] DCLK_PIXEL = 2'h0;
  localparam logic [1:0] DCLK_PIXEL_Q90 = 2'h1;
  localparam logic [1:0] DCLK_PIXEL_X2 = 2'h2;
  localparam logic [1:0] DCLK_INTERNAL = 2'h3;
  // ==========================================================
  // Timing
  localparam int CLK_FREQ_MHZ = 10;
  localparam int OSC_FREQ_MHZ = 40;
  localparam int OSC_HALF_RAW = CLK_FREQ_MHZ / (2 * OSC_FREQ_MHZ);
  localparam int OSC_HALF_CYC = (OSC_HALF_RAW < 1) ? 1 : OSC_HALF_RAW;
  localparam logic [1:0] PLL_LAST = 2'h3;
  localparam int SYNC_DEPTH = 3;
  localparam int PHASE_TAPS = 4;
  localparam int PIPE_DEPTH = 2;
  localparam int SAMPLE_W = 8;
endpackage : poc_pkg
`default_nettype wire

/* testbench/poc_capture.sv */
// Downstream capture register model for the pixel outputs
`default_nettype none
module poc_capture (
  input wire logic dclk_i,
  input wire logic [24:0] bus_i,
  output logic [24:0] cap_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Capture
  // Data and sync taken on the rising data clock only
  always_ff @(posedge dclk_i) begin
    cap_o <= bus_i;
  end
endmodule : poc_capture
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking testbench of the pixel output stage
`default_nettype none
module tb_top
  import poc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Signals
  logic clk_sys_i = 0, sys_rst_i = 1, ext_i = 0, src_i = 0, hs_i = 0, wr_i = 0;
  logic ext_on = 0, hs_o, dclk_o, dk;
  logic [7:0] r_i = 0, g_i = 0, b_i = 0, addr_i = 0, wd_i = 0, rd_o, r_o, g_o, b_o;
  logic [24:0] cap;
  int n_errors = 0, checks = 0, cyc = 0, ph, ph0, ext_rise = 0;
  poc_output poc_output_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .external_pixel_clock_input_i(ext_i), .pixel_source_external_i(src_i),
    .red_sample_i(r_i), .green_sample_i(g_i), .blue_sample_i(b_i), .hsync_regen_i(hs_i),
    .reg_addr_i(addr_i), .reg_wr_i(wr_i), .reg_wdata_i(wd_i), .reg_rd_data_o(rd_o),
    .red_o(r_o), .green_o(g_o), .blue_o(b_o), .horizontal_sync_output_o(hs_o),
    .output_data_clock_o(dclk_o));
  poc_capture poc_capture_inst (.dclk_i(dclk_o), .bus_i({r_o, g_o, b_o, hs_o}), .cap_o(cap));
  // ==========================================================
  // Clocks
  initial begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  // External pixel clock, four system cycles a period, still when off
  always #200 if (ext_on) ext_i = ~ext_i;
  always @(posedge clk_sys_i) cyc <= cyc + 1;
  // Pin edge to visible data is six system edges
  always @(posedge ext_i) ext_rise = cyc;
  // ==========================================================
  // Helpers
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    addr_i = a;
    wd_i = d;
    wr_i = 1;
    @(negedge clk_sys_i);
    wr_i = 0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys_i);
    addr_i = a;
    repeat (2) @(negedge clk_sys_i);
    chk("register", rd_o, e);
  endtask : rreg
  task automatic upd(input logic [7:0] v);
    int n;
    @(negedge clk_sys_i);
    r_i = v;
    g_i = ~v;
    b_i = v ^ 8'h3C;
    hs_i = ~hs_i;
    n = 0;
    while (r_o !== v && n < 20) begin
      @(negedge clk_sys_i);
      n++;
    end
    ph = cyc % 4;
    dk = dclk_o;
    chk("latency", n >= 3 && n <= 7, 1);
    chk("red", r_o, v);
    chk("green", g_o, 8'(~v));
    chk("blue", b_o, v ^ 8'h3C);
    chk("hsync", hs_o, hs_i);
    repeat (6) @(negedge clk_sys_i);
    chk("capture", cap, {r_i, g_i, b_i, hs_i});
  endtask : upd
  task automatic rises(input int e);
    int n;
    logic l;
    n = 0;
    l = dclk_o;
    repeat (16) begin
      @(negedge clk_sys_i);
      n += int'(dclk_o & !l);
      l = dclk_o;
    end
    chk("dclk rises", n, e);
  endtask : rises
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    rreg(8'h04, 8'h00);
    rreg(8'h20, 8'h00);
    wreg(8'h04, 8'hFD);
    wreg(8'h20, 8'hC0);
    wreg(8'h33, 8'h55);
    rreg(8'h04, 8'hFD);
    rreg(8'h20, 8'hC0);
    rreg(8'h33, 8'h00);
    wreg(8'h04, 8'h00);
    wreg(8'h20, 8'h00);
    $display("test regs done");
  endtask : t_regs
  task automatic t_phase;
    upd(8'h80);
    ph0 = ph;
    upd(8'h01);
    chk("same latency", ph, ph0);
    for (int k = 1; k < 4; k++) begin
      wreg(8'h04, 8'(k));
      upd(8'(8'h40 + k));
      chk("phase shift", (ph - ph0 + 4) % 4, k);
      chk("dclk at update", dk, 0);
    end
    wreg(8'h04, 8'h00);
    $display("test phase done");
  endtask : t_phase
  task automatic t_sel;
    logic [2:0] at_upd = 3'b010;
    for (int c = 0; c < 4; c++) begin
      wreg(8'h20, 8'(c << 6));
      upd(8'(8'h90 + c));
      if (c < 3) chk("dclk at update", dk, at_upd[c]);
      rises(c < 2 ? 4 : 8);
    end
    wreg(8'h20, 8'h00);
    $display("test select done");
  endtask : t_sel
  task automatic t_ext;
    src_i = 1;
    ext_on = 1;
    repeat (8) @(negedge clk_sys_i);
    upd(8'hA5);
    chk("external phase", ph, (ext_rise + 2) % 4);
    rises(4);
    ext_on = 0;
    src_i = 0;
    $display("test external done");
  endtask : t_ext
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (12) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    sys_rst_i = 0;
    t_regs();
    t_phase();
    t_sel();
    t_ext();
    test_done();
  end
  initial begin
    #(3000 * 100);
    n_errors++;
    test_done();
  end
endmodule : tb_top
`default_nettype wire
